// ===== rtl/ring_trip_detect.sv
// Purpose: ring trip detection, ringing phase and settle boost
// Assumes: Avalon-MM slave, byte addressing, one word per register
// Notes:   every access completes one cycle after it is seen
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "ring_trip_regs.svh"
module ring_trip_detect #(
  parameter int DB_TICK_CYCLES    = `DEBOUNCE_LSB_NS / `CLK_PERIOD_NS,
  parameter int BOOST_TICK_CYCLES = `BOOST_LSB_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [15:0] ac_current_i,
  input  wire logic [15:0] dc_current_i,
  input  wire logic        current_valid_i,
  input  wire logic        common_mode_high_detect_i,
  input  wire logic        common_mode_low_detect_i,
  input  wire logic        ring_start_i,
  output logic [12:0]      ring_phase_o,
  output logic             ring_phase_load_o,
  output logic             settle_boost_o,
  output logic             ring_trip_o,
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////
  // constants
  // boost periods in lsb units
  localparam logic [15:0] BOOST_DEFAULT_LSB =
    16'(`BOOST_DEFAULT_NS / `BOOST_LSB_NS);
  localparam logic [15:0] DB_TICK_LAST    = 16'(DB_TICK_CYCLES - 1);
  localparam logic [15:0] BOOST_TICK_LAST = 16'(BOOST_TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////
  // declarations
  ring_trip_pkg::top_state_t st_reg;    // registered state
  ring_trip_pkg::top_state_t st_next;   // next state
  logic        req;                     // read or write pending
  logic        done;                    // access completes this edge
  logic [7:0]  idx;                     // word index from address
  logic        ac_detect;               // ac path tripped
  logic        dc_detect;               // dc path tripped
  logic        cm_fire;                 // new common-mode detection
  logic [3:0]  evt;                     // events of this cycle
  logic [15:0] wr16;                    // low half of write data

  ////////////////////////////////////////////////////////////////////
  // helpers
  // true when the index names a register
  function automatic logic mapped(input logic [7:0] i);
    case (i)
      `IDX_RING_PHASE, `IDX_DC_THRESH, `IDX_FILT_COEFF,
      `IDX_AC_THRESH, `IDX_DC_DEBOUNCE, `IDX_AC_DEBOUNCE,
      `IDX_BOOST_TIMER, `IDX_EVT_STATUS, `IDX_EVT_MASK,
      `IDX_LIVE_STATE: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  endfunction

  // boost length in lsb, zero means the default period
  function automatic logic [15:0] boost_len(input logic [15:0] v);
    boost_len = (v == 16'h0000) ? BOOST_DEFAULT_LSB : v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // detection paths
  // ac loop current
  trip_path u_ac_path (
    .clk_sys_i      (clk_sys_i),
    .reset_n_i      (reset_n_i),
    .sample_i       (ac_current_i),
    .sample_valid_i (current_valid_i),
    .coeff_i        (st_reg.cfg.trip_filter_coeff),
    .threshold_i    (st_reg.cfg.ac_trip_threshold),
    .interval_i     (st_reg.cfg.ac_trip_debounce),
    .tick_i         (st_reg.db_tick),
    .detect_o       (ac_detect)
  );

  // dc loop current
  trip_path u_dc_path (
    .clk_sys_i      (clk_sys_i),
    .reset_n_i      (reset_n_i),
    .sample_i       (dc_current_i),
    .sample_valid_i (current_valid_i),
    .coeff_i        (st_reg.cfg.trip_filter_coeff),
    .threshold_i    (st_reg.cfg.dc_trip_threshold),
    .interval_i     (st_reg.cfg.dc_trip_debounce),
    .tick_i         (st_reg.db_tick),
    .detect_o       (dc_detect)
  );

  ////////////////////////////////////////////////////////////////////
  // bus decode
  // a request is served once: wait drops, then rises again
  assign req  = avs_read_i | avs_write_i;
  assign done = req & ~st_reg.waitreq;
  assign idx  = avs_address_i[9:2];
  assign wr16 = avs_writedata_i[15:0];

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    evt     = 4'h0;
    cm_fire = 1'b0;

    // synchronisers for the analogue detectors
    st_next.cm_hi_sync = {st_reg.cm_hi_sync[0], common_mode_high_detect_i};
    st_next.cm_lo_sync = {st_reg.cm_lo_sync[0], common_mode_low_detect_i};
    st_next.cm_prev    = st_reg.cm_hi_sync[1] | st_reg.cm_lo_sync[1];
    cm_fire = (st_reg.cm_hi_sync[1] | st_reg.cm_lo_sync[1]) & ~st_reg.cm_prev;

    // free running debounce tick
    st_next.db_tick = 1'b0;
    if (st_reg.db_prescale >= DB_TICK_LAST) begin
      st_next.db_prescale = 16'h0000;
      st_next.db_tick     = 1'b1;
    end else begin
      st_next.db_prescale = st_reg.db_prescale + 16'h0001;
    end

    // ringing start loads the programmed phase
    st_next.phase_load = ring_start_i;
    if (ring_start_i) begin
      st_next.phase = st_reg.cfg.ring_start_phase[`PHASE_MSB:`PHASE_LSB];
    end

    // settle boost timer
    if (cm_fire) begin
      st_next.boost          = 1'b1;
      st_next.boost_prescale = 16'h0000;
      st_next.boost_left     = boost_len(st_reg.cfg.settle_boost_timer);
      evt[`EVT_BOOST_START]  = 1'b1;
    end else if (st_reg.boost) begin
      // count lsb periods down
      if (st_reg.boost_prescale >= BOOST_TICK_LAST) begin
        st_next.boost_prescale = 16'h0000;
        st_next.boost_left     = st_reg.boost_left - 16'h0001;
        if (st_reg.boost_left <= 16'h0001) begin
          st_next.boost         = 1'b0;
          evt[`EVT_BOOST_END]   = 1'b1;
        end
      end else begin
        st_next.boost_prescale = st_reg.boost_prescale + 16'h0001;
      end
    end

    // ring trip indication
    st_next.trip    = ac_detect | dc_detect;
    st_next.ac_prev = ac_detect;
    st_next.dc_prev = dc_detect;
    evt[`EVT_AC_TRIP] = ac_detect & ~st_reg.ac_prev;
    evt[`EVT_DC_TRIP] = dc_detect & ~st_reg.dc_prev;

    // bus handshake: answer one cycle after a request is seen
    st_next.waitreq = ~(req & st_reg.waitreq);
    if (req && st_reg.waitreq) begin
      // read data stands from this edge on
      st_next.rdata = 32'h0000_0000;
      case (idx)
        `IDX_RING_PHASE:  st_next.rdata[15:0] = st_reg.cfg.ring_start_phase;
        `IDX_DC_THRESH:   st_next.rdata[15:0] = st_reg.cfg.dc_trip_threshold;
        `IDX_FILT_COEFF:  st_next.rdata[15:0] = st_reg.cfg.trip_filter_coeff;
        `IDX_AC_THRESH:   st_next.rdata[15:0] = st_reg.cfg.ac_trip_threshold;
        `IDX_DC_DEBOUNCE: st_next.rdata[15:0] = st_reg.cfg.dc_trip_debounce;
        `IDX_AC_DEBOUNCE: st_next.rdata[15:0] = st_reg.cfg.ac_trip_debounce;
        `IDX_BOOST_TIMER: st_next.rdata[15:0] = st_reg.cfg.settle_boost_timer;
        `IDX_EVT_STATUS:  st_next.rdata[3:0]  = st_reg.status;
        `IDX_EVT_MASK:    st_next.rdata[3:0]  = st_reg.mask;
        // live: trip, ac, dc, boost
        `IDX_LIVE_STATE:  st_next.rdata[3:0]  =
          {st_reg.boost, dc_detect, ac_detect, st_reg.trip};
        // unmapped reads as zero
        default:          st_next.rdata = 32'h0000_0000;
      endcase
    end

    // writes take effect at the completing edge
    if (done && avs_write_i && mapped(idx)) begin
      case (idx)
        `IDX_RING_PHASE:  st_next.cfg.ring_start_phase   = wr16;
        `IDX_DC_THRESH:   st_next.cfg.dc_trip_threshold  = wr16;
        `IDX_FILT_COEFF:  st_next.cfg.trip_filter_coeff  = wr16;
        `IDX_AC_THRESH:   st_next.cfg.ac_trip_threshold  = wr16;
        `IDX_DC_DEBOUNCE: st_next.cfg.dc_trip_debounce   = wr16;
        `IDX_AC_DEBOUNCE: st_next.cfg.ac_trip_debounce   = wr16;
        `IDX_BOOST_TIMER: st_next.cfg.settle_boost_timer = wr16;
        // write one to clear
        `IDX_EVT_STATUS:  st_next.status = st_reg.status & ~wr16[3:0];
        `IDX_EVT_MASK:    st_next.mask   = wr16[3:0];
        // live state is read only
        default:          st_next.status = st_next.status;
      endcase
    end

    // new events win over a clear in the same cycle
    st_next.status = st_next.status | evt;
    st_next.irq    = |(st_reg.status & st_reg.mask);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_reg         <= '0;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.waitreq;
  assign ring_phase_o      = st_reg.phase;
  assign ring_phase_load_o = st_reg.phase_load;
  assign settle_boost_o    = st_reg.boost;
  assign ring_trip_o       = st_reg.trip;
  assign irq_o             = st_reg.irq;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // detector fires, then boost stands
  sequence s_cm_edge;
    (common_mode_high_detect_i || common_mode_low_detect_i) ##1
    (common_mode_high_detect_i || common_mode_low_detect_i) ##1
    (common_mode_high_detect_i || common_mode_low_detect_i);
  endsequence
  sequence s_boost_on;
    ##[1:4] settle_boost_o;
  endsequence

  a_phase_loaded: assert property (
    ring_start_i |=> ring_phase_load_o &&
      ring_phase_o == $past(st_reg.cfg.ring_start_phase[15:3]))
    else $error("ringing phase not loaded");
  a_ac_trip_level: assert property (
    ac_detect |-> $past(u_ac_path.st_reg.filt) > $past(st_reg.cfg.ac_trip_threshold))
    else $error("ac trip without level over threshold");
  a_dc_trip_flag: assert property (
    $rose(dc_detect) |=> st_reg.status[`EVT_DC_TRIP])
    else $error("dc trip not flagged");
  a_ac_trip_flag: assert property (
    $rose(ac_detect) |=> st_reg.status[`EVT_AC_TRIP])
    else $error("ac trip not flagged");
  a_boost_start: assert property (
    (!common_mode_high_detect_i && !common_mode_low_detect_i) ##1 s_cm_edge
    |-> s_boost_on)
    else $error("boost not started");
  a_boost_default: assert property (
    (cm_fire && st_reg.cfg.settle_boost_timer == 16'h0000)
    |=> st_reg.boost_left == 16'd48)
    else $error("default boost length wrong");
  a_reset_clear: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    !reset_n_i |=> st_reg.cfg == '0 && !ring_trip_o)
    else $error("settings not cleared by reset");
  a_trip_follows: assert property (
    (ac_detect || dc_detect) |=> ring_trip_o)
    else $error("ring trip not shown");
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus not answered in one cycle");
endmodule

// ===== rtl/ring_trip_pkg.sv
// Purpose: types of the ring trip and settle block
// Assumes: constants live in ring_trip_regs.svh
// Notes:   all state travels as packed structs
package ring_trip_pkg;
  // software settings, all 16 bit
  typedef struct packed {
    logic [15:0] ring_start_phase;
    logic [15:0] dc_trip_threshold;
    logic [15:0] trip_filter_coeff;
    logic [15:0] ac_trip_threshold;
    logic [15:0] dc_trip_debounce;
    logic [15:0] ac_trip_debounce;
    logic [15:0] settle_boost_timer;
  } cfg_t;
  // one detection path
  typedef struct packed {
    logic [15:0] filt;
    logic [15:0] count;
    logic        detect;
  } path_state_t;
  // whole block
  typedef struct packed {
    cfg_t        cfg;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        irq;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  cm_hi_sync;
    logic [1:0]  cm_lo_sync;
    logic        cm_prev;
    logic [15:0] db_prescale;
    logic        db_tick;
    logic [15:0] boost_prescale;
    logic [15:0] boost_left;
    logic        boost;
    logic [12:0] phase;
    logic        phase_load;
    logic        trip;
    logic        ac_prev;
    logic        dc_prev;
  } top_state_t;
endpackage

// ===== rtl/ring_trip_regs.svh
// Purpose: constants of the ring trip and settle block
// Assumes: 10 MHz system clock
// Notes:   byte address = 4 * index
// Summary of operation
// - ringing starts at programmed phase field
// - ac trip only above ac threshold
// - dc trip only above dc threshold
// - ac detection debounced by own interval
// - dc detection debounced, up to 40.96 s
// - loop current low-pass filtered before compare
// - common-mode detectors start settle boost
// - boost 1.25 ms per lsb, zero is 60 ms
// - all settings clear to zero on reset
`ifndef RING_TRIP_REGS_SVH
`define RING_TRIP_REGS_SVH
// clock and timing
`define CLK_PERIOD_NS      100
`define PHASE_LSB_NS       31250
`define DEBOUNCE_LSB_NS    625000
`define BOOST_LSB_NS       1250000
`define BOOST_DEFAULT_NS   60000000
// register indices
`define IDX_RING_PHASE     8'h3c
`define IDX_DC_THRESH      8'h3e
`define IDX_FILT_COEFF     8'h3f
`define IDX_AC_THRESH      8'h40
`define IDX_DC_DEBOUNCE    8'h41
`define IDX_AC_DEBOUNCE    8'h42
`define IDX_BOOST_TIMER    8'ha8
`define IDX_EVT_STATUS     8'hc0
`define IDX_EVT_MASK       8'hc1
`define IDX_LIVE_STATE     8'hc2
// fields
`define PHASE_MSB          15
`define PHASE_LSB          3
`define EVT_AC_TRIP        0
`define EVT_DC_TRIP        1
`define EVT_BOOST_START    2
`define EVT_BOOST_END      3
// reset values
`define RST_WORD           16'h0000
`define RST_EVT            4'h0
`endif

// ===== rtl/trip_path.sv
// Purpose: filter, compare and debounce of one loop-current path
// Assumes: samples on the system clock with a valid strobe
// Notes:   a zero coefficient freezes the filter output
`include "ring_trip_regs.svh"
module trip_path (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] sample_i,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] coeff_i,
  input  wire logic [15:0] threshold_i,
  input  wire logic [15:0] interval_i,
  input  wire logic        tick_i,
  output logic             detect_o
);
  ring_trip_pkg::path_state_t st_reg;   // registered state
  ring_trip_pkg::path_state_t st_next;  // next state
  logic signed [16:0] diff;             // sample minus filter
  logic signed [33:0] prod;             // diff times coefficient
  logic               above;            // filtered value over threshold
  ////////////////////////////////////////////////////////////////////
  // first order low-pass, compare, debounce
  always_comb begin
    st_next = st_reg;
    diff    = $signed({1'b0, sample_i}) - $signed({1'b0, st_reg.filt});
    prod    = diff * $signed({1'b0, coeff_i});
    above   = st_reg.filt > threshold_i;
    if (sample_valid_i) begin
      st_next.filt = st_reg.filt + prod[31:16];
    end
    if (!above) begin
      st_next.count  = 16'h0000;
      st_next.detect = 1'b0;
    end else begin
      if (tick_i && st_reg.count < interval_i) begin
        st_next.count = st_reg.count + 16'h0001;
      end
      st_next.detect = st_reg.count >= interval_i;
    end
  end
  // register the state
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign detect_o = st_reg.detect;
  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_detect_needs_level: assert property (
    detect_o |-> $past(st_reg.filt > threshold_i))
    else $error("trip without level over threshold");
  a_detect_needs_time: assert property (
    $rose(detect_o) |-> $past(st_reg.count >= interval_i))
    else $error("trip before debounce interval");
  a_filter_frozen: assert property (
    (sample_valid_i && coeff_i == 16'h0000) |=> $stable(st_reg.filt))
    else $error("filter moved with zero coefficient");
endmodule

// ===== tb/tb_ring_trip_detect.sv
// Purpose: self-checking bench of the ring trip and settle block
// Assumes: avalon access completes one cycle after it is seen; short tick parameters
// Notes:   rows cover register access, hand tests cover trip, boost, irq, reset
`include "ring_trip_regs.svh"
module tb_ring_trip_detect;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DB_TICK    = 4;          // debounce lsb in cycles, shortened
  localparam int BOOST_TICK = 4;          // boost lsb in cycles, shortened
  localparam int BOOST_ZERO = 48;         // zero setting means 60 ms at 1.25 ms per lsb
  // register access row: address, write data, expected readback
  typedef struct packed {
    logic [9:0]  adr;
    logic [31:0] wr;
    logic [31:0] exp;
  } row_t;
  logic        clk_sys_i                 = 1'b0;   // system clock
  logic        reset_n_i                 = 1'b0;   // synchronous reset
  logic [9:0]  avs_address_i             = 10'h000;
  logic        avs_read_i                = 1'b0;
  logic        avs_write_i               = 1'b0;
  logic [31:0] avs_writedata_i           = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] ac_current_i              = 16'h0000;
  logic [15:0] dc_current_i              = 16'h0000;
  logic        current_valid_i           = 1'b0;
  logic        common_mode_high_detect_i = 1'b0;
  logic        common_mode_low_detect_i  = 1'b0;
  logic        ring_start_i              = 1'b0;
  logic [12:0] ring_phase_o;
  logic        ring_phase_load_o;
  logic        settle_boost_o;
  logic        ring_trip_o;
  logic        irq_o;
  int          miscompares               = 0;      // mismatch count
  int          tests_run                 = 0;      // comparison count
  logic [31:0] rd;                                 // last read data
  int          n;                                  // loop and wait counter
  row_t        rows [10];                          // register access table
  //////////////////////////////////////////////////////////////////////////////
  // design under test with short ticks
  ring_trip_detect #(
    .DB_TICK_CYCLES    (DB_TICK),
    .BOOST_TICK_CYCLES (BOOST_TICK)
  ) i_ring_trip_detect (
    .clk_sys_i                 (clk_sys_i),
    .reset_n_i                 (reset_n_i),
    .avs_address_i             (avs_address_i),
    .avs_read_i                (avs_read_i),
    .avs_write_i               (avs_write_i),
    .avs_writedata_i           (avs_writedata_i),
    .avs_readdata_o            (avs_readdata_o),
    .avs_waitrequest_o         (avs_waitrequest_o),
    .ac_current_i              (ac_current_i),
    .dc_current_i              (dc_current_i),
    .current_valid_i           (current_valid_i),
    .common_mode_high_detect_i (common_mode_high_detect_i),
    .common_mode_low_detect_i  (common_mode_low_detect_i),
    .ring_start_i              (ring_start_i),
    .ring_phase_o              (ring_phase_o),
    .ring_phase_load_o         (ring_phase_load_o),
    .settle_boost_o            (settle_boost_o),
    .ring_trip_o               (ring_trip_o),
    .irq_o                     (irq_o)
  );
  // 100 ns clock
  always #50 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] adr, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i   <= adr;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  // wait bounded cycles for the trip output to reach a level
  task automatic wait_trip(input logic lvl, input int lim);
    for (n = 0; n < lim && ring_trip_o !== lvl; n++) begin
      @(posedge clk_sys_i);
    end
  endtask
  // start boost from one detector and measure its length
  task automatic boost_run(input logic hi, input int len);
    @(posedge clk_sys_i);
    common_mode_high_detect_i <= hi;
    common_mode_low_detect_i  <= ~hi;
    for (n = 0; n < 10 && settle_boost_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
    end
    check("boost_rise", settle_boost_o, 1'b1);
    for (n = 0; n < 400 && settle_boost_o === 1'b1; n++) begin
      @(posedge clk_sys_i);
    end
    check("boost_len", 32'(n >= len - 1 && n <= len + 1), 1);
    common_mode_high_detect_i <= 1'b0;
    common_mode_low_detect_i  <= 1'b0;
    $display("test boost length %0d done", len);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the expected run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rows[0] = '{{`IDX_RING_PHASE, 2'b00}, 32'hffff_abcd, 32'h0000_abcd};
    rows[1] = '{{`IDX_DC_THRESH, 2'b00}, 32'h0000_ffff, 32'h0000_ffff};
    rows[2] = '{{`IDX_FILT_COEFF, 2'b00}, 32'h0000_ffff, 32'h0000_ffff};
    rows[3] = '{{`IDX_AC_THRESH, 2'b00}, 32'h0000_1000, 32'h0000_1000};
    rows[4] = '{{`IDX_DC_DEBOUNCE, 2'b00}, 32'h0000_000a, 32'h0000_000a};
    rows[5] = '{{`IDX_AC_DEBOUNCE, 2'b00}, 32'h0000_000a, 32'h0000_000a};
    rows[6] = '{{`IDX_BOOST_TIMER, 2'b00}, 32'h0000_0005, 32'h0000_0005};
    rows[7] = '{{`IDX_EVT_MASK, 2'b00}, 32'h0000_0001, 32'h0000_0001};
    rows[8] = '{{`IDX_LIVE_STATE, 2'b00}, 32'h0000_000f, 32'h0000_0000};
    rows[9] = '{10'h3fc, 32'h0000_5555, 32'h0000_0000};
    repeat (10) @(posedge clk_sys_i);
    check("wait_in_reset", avs_waitrequest_o, 1'b1);
    reset_n_i <= 1'b1;
    // reset values of every table location; event status is not read
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, rows[i].adr, 32'h0);
      check("reset_value", rd, 32'h0);
    end
    $display("test reset values done");
    // zero coefficient keeps the filter at rest: no trip at full scale
    @(posedge clk_sys_i);
    ac_current_i    <= 16'hffff;
    dc_current_i    <= 16'hffff;
    current_valid_i <= 1'b1;
    repeat (100) @(posedge clk_sys_i);
    check("trip_coeff_zero", ring_trip_o, 1'b0);
    ac_current_i <= 16'h0000;
    dc_current_i <= 16'h0000;
    $display("test zero coefficient done");
    // register table write then read back
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, rows[i].adr, rows[i].wr);
      bus(1'b0, rows[i].adr, 32'h0);
      check("readback", rd, rows[i].exp);
    end
    $display("test register table done");
    // starting phase handed out on ring start
    @(posedge clk_sys_i);
    ring_start_i <= 1'b1;
    @(posedge clk_sys_i);
    ring_start_i <= 1'b0;
    #1;
    check("phase_load", ring_phase_load_o, 1'b1);
    check("phase_value", 32'(ring_phase_o), 32'h0000_1579);
    $display("test ring phase done");
    // ac path: below threshold never trips, above trips after debounce
    @(posedge clk_sys_i);
    ac_current_i <= 16'h0800;
    repeat (150) @(posedge clk_sys_i);
    check("ac_below", ring_trip_o, 1'b0);
    ac_current_i <= 16'h2000;
    repeat (20) @(posedge clk_sys_i);
    check("ac_debounce_early", ring_trip_o, 1'b0);
    wait_trip(1'b1, 100);
    check("ac_trip", ring_trip_o, 1'b1);
    bus(1'b0, {`IDX_LIVE_STATE, 2'b00}, 32'h0);
    check("live_ac", rd[1:0], 2'b11);
    check("irq_ac", irq_o, 1'b1);
    bus(1'b1, {`IDX_EVT_STATUS, 2'b00}, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_i);
    check("irq_cleared", irq_o, 1'b0);
    ac_current_i <= 16'h0000;
    wait_trip(1'b0, 50);
    check("ac_release", ring_trip_o, 1'b0);
    $display("test ac path done");
    // dc path with its own threshold and debounce, irq masked
    bus(1'b1, {`IDX_DC_THRESH, 2'b00}, 32'h0000_1000);
    @(posedge clk_sys_i);
    dc_current_i <= 16'h0800;
    repeat (150) @(posedge clk_sys_i);
    check("dc_below", ring_trip_o, 1'b0);
    dc_current_i <= 16'h2000;
    repeat (20) @(posedge clk_sys_i);
    check("dc_debounce_early", ring_trip_o, 1'b0);
    wait_trip(1'b1, 100);
    check("dc_trip", ring_trip_o, 1'b1);
    bus(1'b0, {`IDX_EVT_STATUS, 2'b00}, 32'h0);
    check("status_dc", rd[1:0], 2'b10);
    check("irq_masked", irq_o, 1'b0);
    dc_current_i <= 16'h0000;
    wait_trip(1'b0, 50);
    $display("test dc path done");
    // settle boost: programmed length, then zero setting
    boost_run(1'b1, 5 * BOOST_TICK);
    bus(1'b1, {`IDX_BOOST_TIMER, 2'b00}, 32'h0);
    boost_run(1'b0, BOOST_ZERO * BOOST_TICK);
    // second reset in mid-run, during a running boost, clears settings
    @(posedge clk_sys_i);
    common_mode_high_detect_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    check("boost_before_reset", settle_boost_o, 1'b1);
    reset_n_i                 <= 1'b0;
    common_mode_high_detect_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    bus(1'b0, {`IDX_AC_THRESH, 2'b00}, 32'h0);
    check("reset_again", rd, 32'h0);
    check("boost_after_reset", settle_boost_o, 1'b0);
    $display("test second reset done");
    close_out();
  end
endmodule
